// file: pmon_pkg.sv
// constants for the power monitor serial readback slave
// assumes a single system clock; the slave file depends on nothing beyond this package
package pmon_pkg;
  localparam logic [4:0] ADDR_BASE = 5'h0B;
  localparam int CMD_VOLT_CONTINUOUS = 0;
  localparam int CMD_V_ONCE = 1;
  localparam int CMD_CURR_CONTINUOUS = 2;
  localparam int CMD_I_ONCE = 3;
  localparam int CMD_DIVIDER_SELECT = 4;
  localparam int CMD_STATUS = 6;
  localparam int CMD_EXT = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] CMD_RESET = 7'h00;
  localparam logic [11:0] DATA_RESET = 12'h000;
  localparam logic CHAN_VOLT = 1'b0;
  localparam logic CHAN_CURR = 1'b1;
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK, BUS_IGNORE
  } bus_state_t;
endpackage

// file: pmon_i2c_slave.sv
// serial bus slave with conversion sequencer for a voltage/current monitor
// assumes scl/sda are open-drain pins resolved outside; converter handshakes on i_mclk
`timescale 1ns/1ps
`default_nettype none
// Operation
// - one 12-bit converter, multiplexed between current and supply voltage
// - a command may start voltage, current or both conversions at any time
// - results read back as 12 bits in two or three bytes
// - slave only; fast-mode bus rates up to 400 kHz
// - 7-bit address: upper five bits fixed, lower two from strap
// - strap states ground/resistor/float/high give 00/01/10/11
// - address valid straight out of reset, no configuration needed
// - start is sda falling with scl high; begins a transaction
// - eight bits after start: address msb first, then direction bit
// - matched address acknowledged by holding sda low over ninth clock
// - unmatched address leaves sda released until next start
// - each byte is eight data bits plus one acknowledge bit
// - sda changes only with scl low; rising sda with scl high is stop
// - first written byte after address is the command byte
// - master ends a read with no-acknowledge then stop
// - written byte with msb zero is command, msb one is extended write
// - command bits: voltage_continuous_bit, v once, current_continuous_bit, i once, range, status read
// - continuous mode read before first conversion is acked, returns zeros
// - single mode reads not acknowledged until the conversion completes
module pmon_i2c_slave (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [1:0] i_addr_sel,
  output logic o_conv_start,
  output logic o_conv_chan,
  output logic o_voltage_divider_select,
  input wire logic i_conv_done,
  input wire logic [11:0] i_conv_data,
  input wire logic [7:0] i_status,
  output logic o_ext_wr,
  output logic [1:0] o_ext_addr,
  output logic [7:0] o_ext_data
);
  pmon_pkg::bus_state_t state_r, state_nxt;
  logic [2:0] scl_sync_r, sda_sync_r;
  logic scl_r, sda_r, scl_nxt, sda_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt;
  logic rw_r, rw_nxt, first_r, first_nxt, ext_pend_r, ext_pend_nxt, mack_r, mack_nxt;
  logic [1:0] ext_sel_r, ext_sel_nxt, rd_idx_r, rd_idx_nxt;
  logic [6:0] cmd_r, cmd_nxt;
  logic pend_v_r, pend_v_nxt, pend_i_r, pend_i_nxt;
  logic [11:0] v_data_r, v_data_nxt, i_data_r, i_data_nxt;
  logic busy_r, busy_nxt, chan_r, chan_nxt, start_r, start_nxt;
  logic [1:0] lsb_r, lsb_nxt;
  logic lsb_ok_r, lsb_ok_nxt;
  logic oe_r, oe_nxt, ext_wr_r, ext_wr_nxt;
  logic [1:0] ext_addr_r, ext_addr_nxt;
  logic [7:0] ext_data_r, ext_data_nxt;
  logic scl_rise, scl_fall, start_ev, stop_ev, addr_hit, want_v, want_i, cmd_wr;

  function automatic logic [7:0] rd_byte(input logic [1:0] idx, input logic [6:0] cmd,
                                         input logic [11:0] v, input logic [11:0] c,
                                         input logic [7:0] st);
    logic both;
    logic [11:0] one;
    both = cmd[pmon_pkg::CMD_VOLT_CONTINUOUS] | cmd[pmon_pkg::CMD_V_ONCE];
    both = both & (cmd[pmon_pkg::CMD_CURR_CONTINUOUS] | cmd[pmon_pkg::CMD_I_ONCE]);
    one = (cmd[pmon_pkg::CMD_CURR_CONTINUOUS] | cmd[pmon_pkg::CMD_I_ONCE]) ? c : v;
    if (cmd[pmon_pkg::CMD_STATUS])
      rd_byte = st;
    else if (both)
      rd_byte = (idx == 2'h0) ? v[11:4] : (idx == 2'h1) ? c[11:4] : {v[3:0], c[3:0]};
    else
      rd_byte = (idx == 2'h0) ? one[11:4] : {one[3:0], 4'h0};
  endfunction

  always_comb
  begin
    scl_nxt = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_r;
    sda_nxt = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_r;
    scl_rise = scl_nxt & ~scl_r;
    scl_fall = ~scl_nxt & scl_r;
    start_ev = scl_r & scl_nxt & sda_r & ~sda_nxt;
    stop_ev = scl_r & scl_nxt & ~sda_r & sda_nxt;
    addr_hit = (shift_r[7:1] == {pmon_pkg::ADDR_BASE, lsb_r});
    want_v = cmd_r[pmon_pkg::CMD_VOLT_CONTINUOUS] | pend_v_r;
    want_i = cmd_r[pmon_pkg::CMD_CURR_CONTINUOUS] | pend_i_r;
    lsb_ok_nxt = 1'b1;
    lsb_nxt = lsb_ok_r ? lsb_r : i_addr_sel;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    ext_pend_nxt = ext_pend_r;
    ext_sel_nxt = ext_sel_r;
    rd_idx_nxt = rd_idx_r;
    mack_nxt = mack_r;
    cmd_nxt = cmd_r;
    pend_v_nxt = pend_v_r;
    pend_i_nxt = pend_i_r;
    v_data_nxt = v_data_r;
    i_data_nxt = i_data_r;
    oe_nxt = oe_r;
    ext_wr_nxt = 1'b0;
    ext_addr_nxt = ext_addr_r;
    ext_data_nxt = ext_data_r;
    cmd_wr = 1'b0;
    if (start_ev)
    begin
      state_nxt = pmon_pkg::BUS_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end
    else if (stop_ev)
    begin
      state_nxt = pmon_pkg::BUS_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        pmon_pkg::BUS_IDLE, pmon_pkg::BUS_IGNORE: oe_nxt = 1'b0;
        pmon_pkg::BUS_ADDR, pmon_pkg::BUS_WR:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_r};
            cnt_nxt = cnt_r + 4'h1;
          end
          if (scl_fall && cnt_r == pmon_pkg::BITS_PER_BYTE)
          begin
            cnt_nxt = 4'h0;
            if (state_r == pmon_pkg::BUS_ADDR)
            begin
              rw_nxt = shift_r[0];
              first_nxt = 1'b1;
              ext_pend_nxt = 1'b0;
              rd_idx_nxt = 2'h0;
              tx_nxt = rd_byte(2'h0, cmd_r, v_data_r, i_data_r, i_status);
              if (addr_hit && !(shift_r[0] && (pend_v_r || pend_i_r)))
              begin
                state_nxt = pmon_pkg::BUS_ADDR_ACK;
                oe_nxt = 1'b1;
              end
              else
                state_nxt = pmon_pkg::BUS_IGNORE;
            end
            else
            begin
              state_nxt = pmon_pkg::BUS_WR_ACK;
              oe_nxt = 1'b1;
              first_nxt = 1'b0;
              if (first_r && !shift_r[pmon_pkg::CMD_EXT])
              begin
                cmd_wr = 1'b1;
                cmd_nxt = shift_r[6:0] & ~7'h0A;
                pend_v_nxt = shift_r[pmon_pkg::CMD_V_ONCE];
                pend_i_nxt = shift_r[pmon_pkg::CMD_I_ONCE];
                v_data_nxt = pmon_pkg::DATA_RESET;
                i_data_nxt = pmon_pkg::DATA_RESET;
                if (shift_r[pmon_pkg::CMD_V_ONCE])
                  cmd_nxt[pmon_pkg::CMD_V_ONCE] = 1'b1;
                if (shift_r[pmon_pkg::CMD_I_ONCE])
                  cmd_nxt[pmon_pkg::CMD_I_ONCE] = 1'b1;
              end
              else if (first_r)
              begin
                ext_pend_nxt = 1'b1;
                ext_sel_nxt = shift_r[1:0];
              end
              else if (ext_pend_r)
              begin
                ext_pend_nxt = 1'b0;
                ext_wr_nxt = 1'b1;
                ext_addr_nxt = ext_sel_r;
                ext_data_nxt = shift_r;
              end
            end
          end
        end
        pmon_pkg::BUS_ADDR_ACK, pmon_pkg::BUS_WR_ACK:
          if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (rw_r && state_r == pmon_pkg::BUS_ADDR_ACK)
            begin
              state_nxt = pmon_pkg::BUS_RD;
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b1};
            end
            else
            begin
              state_nxt = pmon_pkg::BUS_WR;
              oe_nxt = 1'b0;
            end
          end
        pmon_pkg::BUS_RD:
        begin
          if (scl_rise)
            cnt_nxt = cnt_r + 4'h1;
          if (scl_fall)
          begin
            if (cnt_r == pmon_pkg::BITS_PER_BYTE)
            begin
              state_nxt = pmon_pkg::BUS_RD_ACK;
              oe_nxt = 1'b0;
              rd_idx_nxt = rd_idx_r + 2'h1;
            end
            else
            begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b1};
            end
          end
        end
        pmon_pkg::BUS_RD_ACK:
        begin
          if (scl_rise)
            mack_nxt = ~sda_r;
          if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (mack_r)
            begin
              state_nxt = pmon_pkg::BUS_RD;
              tx_nxt = rd_byte(rd_idx_r, cmd_r, v_data_r, i_data_r, i_status);
              oe_nxt = ~tx_nxt[7];
              tx_nxt = {tx_nxt[6:0], 1'b1};
            end
            else
              state_nxt = pmon_pkg::BUS_IGNORE;
          end
        end
      endcase
    end
    busy_nxt = busy_r;
    chan_nxt = chan_r;
    start_nxt = 1'b0;
    if (busy_r && i_conv_done)
    begin
      busy_nxt = 1'b0;
      if (!cmd_wr)
      begin
        if (chan_r == pmon_pkg::CHAN_VOLT)
        begin
          v_data_nxt = i_conv_data;
          pend_v_nxt = 1'b0;
        end
        else
        begin
          i_data_nxt = i_conv_data;
          pend_i_nxt = 1'b0;
        end
      end
    end
    else if (!busy_r && (want_v || want_i))
    begin
      busy_nxt = 1'b1;
      start_nxt = 1'b1;
      chan_nxt = (want_v && (!want_i || chan_r == pmon_pkg::CHAN_CURR)) ?
                 pmon_pkg::CHAN_VOLT : pmon_pkg::CHAN_CURR;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      state_r <= pmon_pkg::BUS_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'hFF;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ext_pend_r <= 1'b0;
      ext_sel_r <= 2'h0;
      rd_idx_r <= 2'h0;
      mack_r <= 1'b0;
      cmd_r <= pmon_pkg::CMD_RESET;
      pend_v_r <= 1'b0;
      pend_i_r <= 1'b0;
      v_data_r <= pmon_pkg::DATA_RESET;
      i_data_r <= pmon_pkg::DATA_RESET;
      busy_r <= 1'b0;
      chan_r <= pmon_pkg::CHAN_VOLT;
      start_r <= 1'b0;
      lsb_r <= 2'h0;
      lsb_ok_r <= 1'b0;
      oe_r <= 1'b0;
      ext_wr_r <= 1'b0;
      ext_addr_r <= 2'h0;
      ext_data_r <= 8'h00;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[1:0], i_scl};
      sda_sync_r <= {sda_sync_r[1:0], i_sda};
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      ext_pend_r <= ext_pend_nxt;
      ext_sel_r <= ext_sel_nxt;
      rd_idx_r <= rd_idx_nxt;
      mack_r <= mack_nxt;
      cmd_r <= cmd_nxt;
      pend_v_r <= pend_v_nxt;
      pend_i_r <= pend_i_nxt;
      v_data_r <= v_data_nxt;
      i_data_r <= i_data_nxt;
      busy_r <= busy_nxt;
      chan_r <= chan_nxt;
      start_r <= start_nxt;
      lsb_r <= lsb_nxt;
      lsb_ok_r <= lsb_ok_nxt;
      oe_r <= oe_nxt;
      ext_wr_r <= ext_wr_nxt;
      ext_addr_r <= ext_addr_nxt;
      ext_data_r <= ext_data_nxt;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = oe_r;
  assign o_conv_start = start_r;
  assign o_conv_chan = chan_r;
  assign o_voltage_divider_select = cmd_r[pmon_pkg::CMD_DIVIDER_SELECT];
  assign o_ext_wr = ext_wr_r;
  assign o_ext_addr = ext_addr_r;
  assign o_ext_data = ext_data_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_addr_done;
    state_r == pmon_pkg::BUS_ADDR && scl_fall && cnt_r == pmon_pkg::BITS_PER_BYTE
      && !start_ev && !stop_ev;
  endsequence
  property p_start_to_addr;
    start_ev |=> state_r == pmon_pkg::BUS_ADDR && cnt_r == 4'h0 && !o_sda_oe;
  endproperty
  a_start_to_addr: assert property (p_start_to_addr) else $error("start not taken");
  property p_stop_idle;
    stop_ev |=> state_r == pmon_pkg::BUS_IDLE && !o_sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");
  property p_ack_match;
    s_addr_done ##0 (addr_hit && !(shift_r[0] && (pend_v_r || pend_i_r))) |=> o_sda_oe;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("match not acked");
  property p_nack_pending;
    s_addr_done ##0 (shift_r[0] && (pend_v_r || pend_i_r)) |=> !o_sda_oe;
  endproperty
  a_nack_pending: assert property (p_nack_pending) else $error("read acked early");
  property p_ignore_quiet;
    state_r == pmon_pkg::BUS_IGNORE |-> !o_sda_oe;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("sda driven when idle");
  property p_ack_held;
    state_r == pmon_pkg::BUS_ADDR_ACK && !scl_fall && !start_ev && !stop_ev |=> o_sda_oe;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack dropped");
  property p_start_pulse;
    o_conv_start |=> !o_conv_start && $stable(o_conv_chan);
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one pulse");
  property p_cmd_zero;
    cmd_wr |=> v_data_r == pmon_pkg::DATA_RESET && i_data_r == pmon_pkg::DATA_RESET;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("data not cleared");
  property p_addr_stable;
    lsb_ok_r |=> $stable(lsb_r);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved");
  property p_ext_path;
    o_ext_wr |-> $past(ext_pend_r, 2);
  endproperty
  a_ext_path: assert property (p_ext_path) else $error("stray extended write");
endmodule
`default_nettype wire

// file: pmon_bus_master.sv
// bus master model: drives the clock line and pulls the data line low
// assumes the bench resolves the data line with a pull-up; timed on mclk ticks
`timescale 1ns/1ps
`default_nettype none
module pmon_bus_master (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // start, or repeated start from clock low
  task automatic start();
    o_sda_low = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    tick(4);
    o_sda_low = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(4);
    o_sda_low = 1'b0;
    tick(4);
  endtask
  // data moves only with clock low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic q);
    tick(4);
    o_sda_low = ~b;
    tick(4);
    o_scl = 1'b1;
    tick(3);
    q = i_sda;
    tick(1);
    o_scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q);
    bit_io(1'b1, q);
    ack = ~q;
  endtask
  // last byte of a read gets no acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, q);
      d[i] = q;
    end
    bit_io(last, q);
  endtask
endmodule
`default_nettype wire

// file: power_monitor_i2c_readback_slave_bench.sv
// self-checking bench for the serial readback slave
// assumes the bus master model and a behavioural converter below
`timescale 1ns/1ps
`default_nettype none
module power_monitor_i2c_readback_slave_bench;
  localparam logic [11:0] v_val = 12'hA5C;
  localparam logic [11:0] i_val = 12'h3E7;
  localparam logic [7:0] stat_val = 8'hC3;
  localparam logic [7:0] addr_tab [4] = '{8'h58, 8'h5A, 8'h5C, 8'h5E};
  logic i_mclk, i_rst_n, scl, sda, m_low, sda_o, sda_oe, ch;
  logic conv_start, conv_chan, vsel, conv_done, ext_wr;
  logic [1:0] addr_sel, ext_addr;
  logic [11:0] conv_data;
  logic [7:0] ext_data;
  int err_total, n_compared, cyc, n_ext;
  assign sda = ~(m_low | (sda_oe & ~sda_o));
  pmon_i2c_slave pmon_i2c_slave_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_sel(addr_sel),
    .o_conv_start(conv_start), .o_conv_chan(conv_chan), .o_voltage_divider_select(vsel),
    .i_conv_done(conv_done), .i_conv_data(conv_data), .i_status(stat_val),
    .o_ext_wr(ext_wr), .o_ext_addr(ext_addr), .o_ext_data(ext_data));
  pmon_bus_master pmon_bus_master_inst (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(m_low));
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // converter: one conversion at a time, 2000 cycles each
  initial
  begin
    conv_done = 1'b0;
    conv_data = 12'h000;
    forever
    begin
      @(posedge i_mclk);
      #1;
      conv_done = 1'b0;
      if (conv_start === 1'b1)
      begin
        ch = conv_chan;
        repeat (2000) @(posedge i_mclk);
        #1;
        conv_data = ch ? i_val : v_val;
        conv_done = 1'b1;
      end
    end
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (ext_wr === 1'b1)
      n_ext++;
    if (cyc == 60000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge i_mclk);
    #1;
    i_rst_n = 1'b0;
    addr_sel = s;
    repeat (3) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    repeat (6) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1,
    input int nb, output logic ack);
    logic k;
    pmon_bus_master_inst.start();
    pmon_bus_master_inst.wbyte(a, ack);
    if (ack && nb > 0)
      pmon_bus_master_inst.wbyte(b0, k);
    if (ack && nb > 1)
      pmon_bus_master_inst.wbyte(b1, k);
    pmon_bus_master_inst.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int nb, output logic ack,
    output logic [7:0] q [3]);
    pmon_bus_master_inst.start();
    pmon_bus_master_inst.wbyte(a | 8'h01, ack);
    for (int i = 0; i < nb; i++)
      if (ack)
        pmon_bus_master_inst.rbyte(i == nb - 1, q[i]);
    pmon_bus_master_inst.stop();
  endtask
  initial
  begin
    logic ack;
    logic [7:0] q [3];
    logic [7:0] a;
    logic k;
    int n0;
    i_rst_n = 1'b0;
    addr_sel = 2'b00;
    repeat (3) @(posedge i_mclk);
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      chk("idle sda_oe", 12'h000, {11'h000, sda_oe});
      wr(addr_tab[s] ^ 8'h02, 8'h00, 8'h00, 0, ack);
      chk("foreign address ack", 12'h000, {11'h000, ack});
      wr(addr_tab[s], 8'h00, 8'h00, 0, ack);
      chk("own address ack", 12'h001, {11'h000, ack});
    end
    $display("test address done");
    a = addr_tab[3];
    wr(a, 8'h01, 8'h00, 1, ack);
    rd(a, 2, ack, q);
    chk("early read ack", 12'h001, {11'h000, ack});
    chk("early read data", 12'h000, {q[0], q[1][7:4]});
    repeat (2200) @(posedge i_mclk);
    rd(a, 2, ack, q);
    chk("voltage hi", {4'h0, v_val[11:4]}, {4'h0, q[0]});
    chk("voltage lo", {4'h0, v_val[3:0], 4'h0}, {4'h0, q[1]});
    chk("voltage channel", 12'h000, {11'h000, ch});
    $display("test voltage continuous done");
    wr(a, 8'h08, 8'h00, 1, ack);
    rd(a, 2, ack, q);
    chk("pending read ack", 12'h000, {11'h000, ack});
    repeat (4400) @(posedge i_mclk);
    rd(a, 2, ack, q);
    chk("done read ack", 12'h001, {11'h000, ack});
    chk("current", i_val, {q[0], q[1][7:4]});
    chk("current channel", 12'h001, {11'h000, ch});
    $display("test current once done");
    wr(a, 8'h05, 8'h00, 1, ack);
    repeat (4400) @(posedge i_mclk);
    rd(a, 3, ack, q);
    chk("both v hi", {4'h0, v_val[11:4]}, {4'h0, q[0]});
    chk("both i hi", {4'h0, i_val[11:4]}, {4'h0, q[1]});
    chk("both lo", {4'h0, v_val[3:0], i_val[3:0]}, {4'h0, q[2]});
    $display("test both continuous done");
    wr(a, 8'h40, 8'h00, 1, ack);
    rd(a, 1, ack, q);
    chk("status byte", {4'h0, stat_val}, {4'h0, q[0]});
    pmon_bus_master_inst.start();
    pmon_bus_master_inst.bit_io(1'b0, k);
    pmon_bus_master_inst.bit_io(1'b1, k);
    pmon_bus_master_inst.bit_io(1'b0, k);
    wr(a, 8'h10, 8'h00, 1, ack);
    chk("ack after abort", 12'h001, {11'h000, ack});
    chk("divider select", 12'h001, {11'h000, vsel});
    $display("test status and abort done");
    n0 = n_ext;
    wr(a, 8'h82, 8'h5A, 2, ack);
    chk("ext write pulses", 12'h001, 12'(n_ext - n0));
    chk("ext addr", 12'h002, {10'h000, ext_addr});
    chk("ext data", 12'h05A, {4'h0, ext_data});
    $display("test extended write done");
    complete_run();
  end
endmodule
`default_nettype wire
